// ==== inc/rlc_consts.svh ====
/*
  Constants of the remote/local control front end: character codes,
  command words, bus message codes and serial timing counts.
  Assumes it is included by bare name from the modules.
*/
`ifndef RLC_CONSTS_SVH
`define RLC_CONSTS_SVH

// Serial timing, rate in Hz and baud
`define RLC_CLK_HZ     10000000
`define RLC_BAUD       9600
`define RLC_BIT_CYC    (`RLC_CLK_HZ / `RLC_BAUD)
`define RLC_HALF_CYC   (`RLC_BIT_CYC / 2)
`define RLC_DATA_BITS  8
`define RLC_STOP_BITS  1

// Character codes
`define RLC_CHR_CR     8'h0D
`define RLC_CHR_LF     8'h0A
`define RLC_CHR_SEMI   8'h3B
`define RLC_CHR_STAR   8'h2A
`define RLC_CHR_SPACE  8'h20
`define RLC_CHR_TAB    8'h09
`define RLC_CHR_XON    8'h11
`define RLC_CHR_XOFF   8'h13
`define RLC_CHR_LOW_A  8'h61
`define RLC_CHR_LOW_Z  8'h7A
`define RLC_CASE_BIT   8'h20

// Command words, right aligned
`define RLC_WORD_LOCAL   40'h4C4F43414C
`define RLC_WORD_REMOTE  48'h52454D4F5445
`define RLC_WORD_LOCKOUT 56'h4C4F434B4F5554
`define RLC_WORD_IDN     40'h2A49444E3F

// Bus messages sent with ATN true
`define RLC_MSG_GTL    8'h01
`define RLC_MSG_LLO    8'h11

`endif

// ==== inc/rlc_pkg.sv ====
/*
  Types of the remote/local control front end.
  Assumes rlc_consts.svh sits on the include path.
*/
package rlc_pkg;

  // Operating state, one-hot
  typedef enum logic [3:0] {
    ST_LOCAL      = 4'h1,
    ST_LOCAL_LOCK = 4'h2,
    ST_REMOTE     = 4'h4,
    ST_REMOTE_LOCK = 4'h8
  } ctl_state_t;

  // Origin of a command byte
  typedef enum logic [0:0] {
    SRC_SERIAL = 1'h0,
    SRC_BUS    = 1'h1
  } src_t;

endpackage

// ==== verilog/pair_buffer.sv ====
/*
  Two-entry buffer with valid/ready on both sides; head comes from a flop.
  Assumes one clock, synchronous active-high reset and a clock enable.
*/
`timescale 1ns/1ps
module pair_buffer
#(
  parameter int W = 11
)
(
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         ce,
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output logic              in_ready,
  output logic [W-1:0]      out_data,
  output logic              out_valid,
  input  wire logic         out_ready
);

  logic [W-1:0] tail_q;   // Second entry
  logic         full_q;   // Second entry holds a word
  logic         push;     // Word accepted
  logic         pop;      // Word delivered

  assign push     = in_valid & ~full_q;
  assign pop      = out_ready & out_valid;
  assign in_ready = ~full_q;

  ////////////////////////////////////////////////////////////////////////////
  // Head and tail update; a full buffer refuses until the head drains
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      out_valid <= '0;
      full_q    <= '0;
      out_data  <= '0;
      tail_q    <= '0;
    end
    else if (ce)
    begin
      if (pop)
      begin
        // Head leaves; tail or new word moves up
        out_data  <= full_q ? tail_q : in_data;
        out_valid <= full_q | push;
        full_q    <= full_q & push;
        if (push)
          tail_q <= in_data;
      end
      else if (push)
      begin
        // Fill head first, then tail
        if (out_valid)
        begin
          tail_q <= in_data;
          full_q <= '1;
        end
        else
        begin
          out_data  <= in_data;
          out_valid <= '1;
        end
      end
    end
  end

endmodule

// ==== verilog/remote_local_control_front.sv ====
/*
  Remote-control front end: serial receiver and transmitter, bus data and
  message intake, case folding, command word matching and the four-state
  local/remote/lockout controller with front-panel gating.
  Assumes a bus engine on the same clock delivers bytes, ATN and the
  listen-addressed state, and that the panel scanner is on the same clock.
*/
`timescale 1ns/1ps
`include "rlc_consts.svh"
module remote_local_control_front
  import rlc_pkg::*;
#(
  parameter int                ID_LEN  = 16,
  parameter logic [8*ID_LEN-1:0] ID_TEXT = {"ANYCO,CAL,0,1.0", `RLC_CHR_CR} // Arbitrary
)
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       ce,
  input  wire logic       ser_rx_pin,
  output logic            ser_tx_pin,
  input  wire logic       ren_pin,
  input  wire logic       bus_listen,
  input  wire logic [7:0] bus_byte,
  input  wire logic       bus_atn,
  input  wire logic       bus_byte_valid,
  output logic            bus_byte_ready,
  output logic [7:0]      talk_data,
  output logic            talk_valid,
  input  wire logic       talk_ready,
  input  wire logic       key_local_pin,
  input  wire logic [7:0] key_code,
  input  wire logic       key_valid,
  output logic [7:0]      panel_code,
  output logic            panel_valid,
  output logic [7:0]      cmd_data,
  output logic            cmd_src,
  output logic            cmd_common,
  output logic            cmd_end,
  output logic            cmd_valid,
  input  wire logic       cmd_ready,
  output logic            remote_ind,
  output logic            lockout_ind,
  output logic            rx_overrun
);

  localparam int IW = $clog2(ID_LEN + 1);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: serial line, REN, local key
  logic [2:0] pin_raw;     // Raw pins
  logic [2:0] sync1_q;     // First stage, read by second only
  logic [2:0] sync2_q;     // Second stage
  logic       ren_old_q;   // REN last cycle
  logic       key_old_q;   // Local key last cycle
  logic       rx_line;
  logic       ren_s;
  logic       key_s;

  assign pin_raw = {key_local_pin, ren_pin, ser_rx_pin};
  for (genvar g = 0; g < 3; g++)
  begin : g_sync
    // Two flops per pin
    always_ff @(posedge clk)
    begin
      if (rst)
      begin
        sync1_q[g] <= 1'h1 ^ (g != 0);
        sync2_q[g] <= 1'h1 ^ (g != 0);
      end
      else if (ce)
      begin
        sync1_q[g] <= pin_raw[g];
        sync2_q[g] <= sync1_q[g];
      end
    end
  end
  assign rx_line = sync2_q[0];
  assign ren_s   = sync2_q[1];
  assign key_s   = sync2_q[2];

  ////////////////////////////////////////////////////////////////////////////
  // Serial receiver, fixed 8N1 at the set rate
  logic [10:0] rx_cnt_q;   // Baud counter
  logic [3:0]  rx_bit_q;   // 0 idle, 1 start, 2..9 data, 10 stop
  logic [7:0]  rx_sh_q;    // Data shifter
  logic        rx_done_q;  // Byte ready pulse

  // Sample mid-bit; a glitch start is dropped
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rx_cnt_q  <= '0;
      rx_bit_q  <= '0;
      rx_sh_q   <= '0;
      rx_done_q <= '0;
    end
    else if (ce)
    begin
      rx_done_q <= '0;
      if (rx_bit_q == 4'h0)
      begin
        if (!rx_line)
        begin
          rx_bit_q <= 4'h1;
          rx_cnt_q <= 11'(`RLC_HALF_CYC - 1);
        end
      end
      else if (rx_cnt_q != 11'h000)
        rx_cnt_q <= rx_cnt_q - 11'h001;
      else
      begin
        rx_cnt_q <= 11'(`RLC_BIT_CYC - 1);
        if (rx_bit_q == 4'h1)
          rx_bit_q <= rx_line ? 4'h0 : 4'h2;
        else if (rx_bit_q == 4'(`RLC_DATA_BITS + 2))
        begin
          // Stop bit must be high; no parity is checked
          rx_done_q <= rx_line;
          rx_bit_q  <= 4'h0;
        end
        else
        begin
          rx_sh_q  <= {rx_line, rx_sh_q[7:1]};
          rx_bit_q <= rx_bit_q + 4'h1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Intake: case folding and one holding stage per source
  logic [7:0] ser_up;        // Folded serial byte
  logic [7:0] bus_up;        // Folded bus byte
  logic       rx_flow;       // Received XON or XOFF
  logic       bus_data_take; // Bus data byte accepted
  logic       bus_msg;       // Bus message byte
  logic [7:0] ser_hold_q;    // Serial byte waiting
  logic       ser_hv_q;
  logic [7:0] bus_hold_q;    // Bus byte waiting
  logic       tx_pause_q;    // Host sent XOFF
  logic       buf_ready;
  logic       push_ser;
  logic       push_bus;

  function automatic logic [7:0] fold(input logic [7:0] c);
    fold = (c >= `RLC_CHR_LOW_A && c <= `RLC_CHR_LOW_Z) ? (c & ~`RLC_CASE_BIT) : c;
  endfunction

  assign ser_up   = fold(rx_sh_q);
  assign bus_up   = fold(bus_byte);
  assign rx_flow  = (rx_sh_q == `RLC_CHR_XON) || (rx_sh_q == `RLC_CHR_XOFF);
  assign bus_data_take = bus_byte_valid & bus_byte_ready & ~bus_atn;
  assign bus_msg  = bus_byte_valid & bus_atn;
  assign push_ser = ser_hv_q & buf_ready;
  assign push_bus = ~bus_byte_ready & buf_ready & ~ser_hv_q;

  // Serial wins the buffer; the bus stage holds NRFD by dropping ready
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ser_hold_q     <= '0;
      ser_hv_q       <= '0;
      bus_hold_q     <= '0;
      bus_byte_ready <= '1;
      tx_pause_q     <= '0;
      rx_overrun     <= '0;
    end
    else if (ce)
    begin
      if (rx_done_q && rx_flow)
        tx_pause_q <= (rx_sh_q == `RLC_CHR_XOFF);
      else if (rx_done_q)
      begin
        // A byte over a full stage replaces the waiting byte; the loss is flagged
        rx_overrun <= rx_overrun | (ser_hv_q & ~push_ser);
        ser_hold_q <= ser_up;
        ser_hv_q   <= '1;
      end
      else if (push_ser)
        ser_hv_q <= '0;
      if (bus_data_take)
      begin
        bus_hold_q     <= bus_up;
        bus_byte_ready <= '0;
      end
      else if (push_bus)
        bus_byte_ready <= '1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command word matching, one tracker per source
  logic [7:0]  in_ch;        // Byte entering the buffer
  logic        in_src;
  logic        in_push;
  logic        in_term;      // CR, LF or semicolon
  logic        in_blank;
  logic [63:0] word_q [2];   // Last word characters
  logic [3:0]  len_q  [2];   // Word length, saturating
  logic        done_q [2];   // Word ended by a blank
  logic        star_q [2];   // Command opened with an asterisk
  logic        in_first;
  logic        in_common;
  logic        hit_local;
  logic        hit_remote;
  logic        hit_lock;
  logic        hit_idn;

  assign in_ch    = push_ser ? ser_hold_q : bus_hold_q;
  assign in_src   = push_ser ? SRC_SERIAL : SRC_BUS;
  assign in_push  = push_ser | push_bus;
  assign in_term  = (in_ch == `RLC_CHR_CR) || (in_ch == `RLC_CHR_LF) ||
                    (in_ch == `RLC_CHR_SEMI);
  assign in_blank = (in_ch == `RLC_CHR_SPACE) || (in_ch == `RLC_CHR_TAB);
  assign in_first = (len_q[in_src] == 4'h0) && !in_blank && !in_term;
  assign in_common = star_q[in_src] | (in_first & (in_ch == `RLC_CHR_STAR));

  // Word match at each terminator; serial-only words need the serial source
  assign hit_local  = in_push & in_term & (in_src == SRC_SERIAL) & (len_q[0] == 4'h5) &
                      (word_q[0][39:0] == `RLC_WORD_LOCAL);
  assign hit_remote = in_push & in_term & (in_src == SRC_SERIAL) & (len_q[0] == 4'h6) &
                      (word_q[0][47:0] == `RLC_WORD_REMOTE);
  assign hit_lock   = in_push & in_term & (in_src == SRC_SERIAL) & (len_q[0] == 4'h7) &
                      (word_q[0][55:0] == `RLC_WORD_LOCKOUT);
  assign hit_idn    = in_push & in_term & (len_q[in_src] == 4'h5) &
                      (word_q[in_src][39:0] == `RLC_WORD_IDN);

  for (genvar s = 0; s < 2; s++)
  begin : g_word
    // Leading blanks skipped, trailing text after a blank ignored
    always_ff @(posedge clk)
    begin
      if (rst || (ce && in_push && in_src == s && in_term))
      begin
        word_q[s] <= '0;
        len_q[s]  <= '0;
        done_q[s] <= '0;
        star_q[s] <= '0;
      end
      else if (ce && in_push && in_src == s)
      begin
        if (in_blank)
          done_q[s] <= (len_q[s] != 4'h0);
        else if (!done_q[s])
        begin
          word_q[s] <= {word_q[s][55:0], in_ch};
          len_q[s]  <= (len_q[s] == 4'hF) ? len_q[s] : len_q[s] + 4'h1;
          if (len_q[s] == 4'h0)
            star_q[s] <= (in_ch == `RLC_CHR_STAR);
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command stream buffer toward the parser
  pair_buffer #(.W(11)) u_buf
  (
    .clk       (clk),
    .rst       (rst),
    .ce        (ce),
    .in_data   ({in_src, in_common, in_term, in_ch}),
    .in_valid  (in_push),
    .in_ready  (buf_ready),
    .out_data  ({cmd_src, cmd_common, cmd_end, cmd_data}),
    .out_valid (cmd_valid),
    .out_ready (cmd_ready)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Local/remote/lockout controller
  ctl_state_t st_q;
  ctl_state_t st_d;
  logic       listen_old_q;   // Addressed-with-REN last cycle
  logic       key_press;
  logic       ren_fall;
  logic       mla_rise;
  logic       gtl_bus;
  logic       llo_bus;
  logic       go_remote;
  logic       go_local;
  logic       go_lock;

  assign key_press = key_s & ~key_old_q;
  assign ren_fall  = ~ren_s & ren_old_q;
  assign mla_rise  = ren_s & bus_listen & ~listen_old_q;
  assign gtl_bus   = bus_msg & bus_listen & (bus_byte == `RLC_MSG_GTL);
  assign llo_bus   = bus_msg & (bus_byte == `RLC_MSG_LLO);
  assign go_remote = hit_remote | mla_rise;
  assign go_local  = hit_local | gtl_bus;
  assign go_lock   = hit_lock | llo_bus;

  // A fall of REN outranks other requests in the remote and lockout states only
  always_comb
  begin
    st_d = st_q;
    case (st_q)
      ST_LOCAL:
        if (go_remote)
          st_d = ST_REMOTE;
        else if (go_lock)
          st_d = ST_LOCAL_LOCK;
      ST_REMOTE:
        if (ren_fall || key_press || go_local)
          st_d = ST_LOCAL;
        else if (go_lock)
          st_d = ST_REMOTE_LOCK;
      ST_LOCAL_LOCK:
        if (ren_fall || hit_local)
          st_d = ST_LOCAL;
        else if (go_remote)
          st_d = ST_REMOTE_LOCK;
      ST_REMOTE_LOCK:
        if (ren_fall)
          st_d = ST_LOCAL;
        else if (go_local)
          st_d = ST_LOCAL_LOCK;
      default:
        st_d = ST_LOCAL;
    endcase
  end

  // State, indicators and gated panel keys
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st_q         <= ST_LOCAL;
      remote_ind   <= '0;
      lockout_ind  <= '0;
      panel_code   <= '0;
      panel_valid  <= '0;
      ren_old_q    <= '0;
      key_old_q    <= '0;
      listen_old_q <= '0;
    end
    else if (ce)
    begin
      st_q         <= st_d;
      remote_ind   <= (st_d == ST_REMOTE) || (st_d == ST_REMOTE_LOCK);
      lockout_ind  <= (st_d == ST_LOCAL_LOCK) || (st_d == ST_REMOTE_LOCK);
      panel_code   <= key_code;
      panel_valid  <= key_valid && ((st_q == ST_LOCAL) || (st_q == ST_LOCAL_LOCK));
      ren_old_q    <= ren_s;
      key_old_q    <= key_s;
      listen_old_q <= ren_s & bus_listen;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Identification answer, serial transmitter and bus talk output
  logic [IW-1:0] id_idx_q;   // Next character
  logic          id_busy_q;
  logic          id_bus_q;   // Answer goes out on the bus
  logic          id_last;
  logic [7:0]    id_ch;
  logic [9:0]    tx_sh_q;    // Stop, data, start
  logic [3:0]    tx_bit_q;   // 0 idle
  logic [10:0]   tx_cnt_q;
  logic          xoff_sent_q;
  logic          tx_idle;
  logic          flow_due;   // XON or XOFF owed to the host
  logic          tx_id;      // Serial takes an answer byte
  logic          bus_id;     // Talk register takes an answer byte

  assign id_ch    = ID_TEXT[8*(ID_LEN - 1 - int'(id_idx_q)) +: 8];
  assign id_last  = (id_idx_q == IW'(ID_LEN - 1));
  assign tx_idle  = (tx_bit_q == 4'h0);
  assign flow_due = (xoff_sent_q == buf_ready);
  assign tx_id    = tx_idle & ~flow_due & ~tx_pause_q & id_busy_q & ~id_bus_q;
  assign bus_id   = id_busy_q & id_bus_q & (~talk_valid | talk_ready);

  // Answers are only sent when asked; a query during an answer is dropped
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      id_idx_q    <= '0;
      id_busy_q   <= '0;
      id_bus_q    <= '0;
      tx_sh_q     <= '1;
      tx_bit_q    <= '0;
      tx_cnt_q    <= '0;
      ser_tx_pin  <= '1;
      xoff_sent_q <= '0;
      talk_data   <= '0;
      talk_valid  <= '0;
    end
    else if (ce)
    begin
      if (hit_idn && !id_busy_q)
      begin
        id_busy_q <= '1;
        id_bus_q  <= (in_src == SRC_BUS);
        id_idx_q  <= '0;
      end
      else if (tx_id || bus_id)
      begin
        id_idx_q  <= id_idx_q + IW'(1);
        id_busy_q <= ~id_last;
      end
      if (bus_id)
      begin
        talk_data  <= id_ch;
        talk_valid <= '1;
      end
      else if (talk_ready)
        talk_valid <= '0;
      if (tx_idle && flow_due)
      begin
        tx_sh_q     <= {1'h1, (buf_ready ? `RLC_CHR_XON : `RLC_CHR_XOFF), 1'h0};
        xoff_sent_q <= ~buf_ready;
        tx_bit_q    <= 4'(`RLC_DATA_BITS + `RLC_STOP_BITS + 2);
        tx_cnt_q    <= '0;
      end
      else if (tx_id)
      begin
        tx_sh_q  <= {1'h1, id_ch, 1'h0};
        tx_bit_q <= 4'(`RLC_DATA_BITS + `RLC_STOP_BITS + 2);
        tx_cnt_q <= '0;
      end
      else if (!tx_idle)
      begin
        if (tx_cnt_q != 11'h000)
          tx_cnt_q <= tx_cnt_q - 11'h001;
        else
        begin
          // Last step only waits out the stop bit
          tx_cnt_q <= 11'(`RLC_BIT_CYC - 1);
          tx_bit_q <= tx_bit_q - 4'h1;
          if (tx_bit_q != 4'h1)
          begin
            ser_tx_pin <= tx_sh_q[0];
            tx_sh_q    <= {1'h1, tx_sh_q[9:1]};
          end
        end
      end
    end
  end

endmodule

// ==== verif/rlc_monitor.sv ====
/*
  Port checker for the remote/local control front end.
  Assumes it is bound to the top module; one clock, reset high.
*/
`timescale 1ns/1ps
`include "rlc_consts.svh"
module rlc_monitor
(
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       ren_pin,
  input wire logic       bus_listen,
  input wire logic [7:0] bus_byte,
  input wire logic       bus_atn,
  input wire logic       bus_byte_valid,
  input wire logic [7:0] key_code,
  input wire logic       key_valid,
  input wire logic [7:0] panel_code,
  input wire logic       panel_valid,
  input wire logic [7:0] cmd_data,
  input wire logic       cmd_end,
  input wire logic       cmd_valid,
  input wire logic       cmd_ready,
  input wire logic [7:0] talk_data,
  input wire logic       talk_valid,
  input wire logic       talk_ready,
  input wire logic       remote_ind,
  input wire logic       lockout_ind,
  input wire logic       ser_tx_pin,
  input wire logic       rx_overrun
);
  // One domain only
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  AST_RESET: assert property (
    $fell(rst) |-> !remote_ind && !lockout_ind && !cmd_valid && ser_tx_pin && !rx_overrun)
    else $error("state after reset wrong");
  AST_PANEL: assert property (
    key_valid && !remote_ind |=> panel_valid && panel_code == $past(key_code))
    else $error("panel key lost in local");
  AST_GATE: assert property (
    key_valid && remote_ind |=> !panel_valid) else $error("panel key passed in remote");
  AST_LLO: assert property (
    bus_byte_valid && bus_atn && bus_byte == `RLC_MSG_LLO |=> lockout_ind)
    else $error("lockout message ignored");
  // Two sync stages plus the state edge
  AST_REN_FALL: assert property (
    $fell(ren_pin) |-> ##[2:4] (!remote_ind && !lockout_ind)) else $error("no local on REN low");
  AST_REN_RISE: assert property (
    $rose(ren_pin) && bus_listen && !lockout_ind |-> ##[2:4] remote_ind)
    else $error("no remote on REN high");
  AST_UPPER: assert property (
    cmd_valid |-> !(cmd_data inside {[`RLC_CHR_LOW_A:`RLC_CHR_LOW_Z]}))
    else $error("lower case passed on");
  AST_END: assert property (
    cmd_valid |-> cmd_end == (cmd_data inside {`RLC_CHR_CR, `RLC_CHR_LF, `RLC_CHR_SEMI}))
    else $error("end marker wrong");
  AST_HOLD: assert property (
    cmd_valid && !cmd_ready |=> cmd_valid && $stable(cmd_data)) else $error("command dropped");
  AST_TALK: assert property (
    talk_valid && !talk_ready |=> talk_valid && $stable(talk_data)) else $error("answer dropped");
endmodule

bind remote_local_control_front rlc_monitor rlc_monitor_i (
  .clk(clk), .rst(rst), .ren_pin(ren_pin), .bus_listen(bus_listen), .bus_byte(bus_byte),
  .bus_atn(bus_atn), .bus_byte_valid(bus_byte_valid), .key_code(key_code),
  .key_valid(key_valid), .panel_code(panel_code), .panel_valid(panel_valid),
  .cmd_data(cmd_data), .cmd_end(cmd_end), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
  .talk_data(talk_data), .talk_valid(talk_valid), .talk_ready(talk_ready),
  .remote_ind(remote_ind), .lockout_ind(lockout_ind), .ser_tx_pin(ser_tx_pin),
  .rx_overrun(rx_overrun));

// ==== verif/serial_host.sv ====
/*
  Host PC model on the serial line: sends and receives 8N1 frames.
  Assumes the shared 10 MHz clock for bit timing.
*/
`timescale 1ns/1ps
`include "rlc_consts.svh"
module serial_host
(
  input wire logic clk,
  input wire logic tx_line,
  output logic     rx_line
);
  localparam int BITC = `RLC_BIT_CYC;
  logic [7:0] rb_q;     // Last byte heard
  logic       xoff_q = 1'b0; // Device asked us to pause
  initial rx_line = 1'b1;
  // Receiver, sampled mid bit
  always
  begin
    @(negedge tx_line);
    repeat (BITC / 2) @(posedge clk);
    for (int i = 0; i < 8; i++)
    begin
      repeat (BITC) @(posedge clk);
      rb_q[i] = tx_line;
    end
    repeat (BITC) @(posedge clk);
    if (rb_q == `RLC_CHR_XOFF) xoff_q = 1'b1;
    if (rb_q == `RLC_CHR_XON) xoff_q = 1'b0;
  end
  // One frame: start, 8 bits LSB first, stop; line idles high
  task automatic send(input logic [7:0] b);
    while (xoff_q) @(posedge clk);
    #10 rx_line = 1'b0;
    repeat (BITC) @(posedge clk);
    for (int i = 0; i < 8; i++)
    begin
      #10 rx_line = b[i];
      repeat (BITC) @(posedge clk);
    end
    #10 rx_line = 1'b1;
    repeat (BITC) @(posedge clk);
  endtask
endmodule

// ==== verif/tb.sv ====
/*
  Self-checking bench for the control front end: bus, panel, serial.
  Assumes the bound checker and the serial host model.
*/
`timescale 1ns/1ps
`include "rlc_consts.svh"
module tb
  import rlc_pkg::*;
;
  localparam int DLY = 10;
  localparam logic [127:0] ID_T = {"TBCO,CAL,99,2.0", 8'h0D}; // Arbitrary
  logic clk, rst, ce, rxp, txp, ren_pin, bus_listen, bus_atn, bus_byte_valid, bus_byte_ready;
  logic talk_valid, talk_ready = 1'b0, key_local_pin, key_valid, panel_valid, cmd_src, cmd_common;
  logic cmd_end, cmd_valid, cmd_ready, remote_ind, lockout_ind, rx_overrun;
  logic [7:0] bus_byte, talk_data, key_code, panel_code, cmd_data;
  logic [10:0] cq[$];  // Commands seen
  logic [7:0]  tq[$];  // Answer bytes seen
  int error_cnt = 0;
  int n_checks = 0;
  remote_local_control_front #(.ID_LEN(16), .ID_TEXT(ID_T)) remote_local_control_front_i (
    .clk(clk), .rst(rst), .ce(ce), .ser_rx_pin(rxp), .ser_tx_pin(txp), .ren_pin(ren_pin),
    .bus_listen(bus_listen), .bus_byte(bus_byte), .bus_atn(bus_atn),
    .bus_byte_valid(bus_byte_valid), .bus_byte_ready(bus_byte_ready), .talk_data(talk_data),
    .talk_valid(talk_valid), .talk_ready(talk_ready), .key_local_pin(key_local_pin),
    .key_code(key_code), .key_valid(key_valid), .panel_code(panel_code),
    .panel_valid(panel_valid), .cmd_data(cmd_data), .cmd_src(cmd_src),
    .cmd_common(cmd_common), .cmd_end(cmd_end), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .remote_ind(remote_ind), .lockout_ind(lockout_ind), .rx_overrun(rx_overrun));
  serial_host serial_host_i (.clk(clk), .tx_line(txp), .rx_line(rxp));
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Capture accepted outputs; answer side stalls every other cycle
  always @(posedge clk)
  begin
    if (cmd_valid && cmd_ready) cq.push_back({cmd_src, cmd_common, cmd_end, cmd_data});
    if (talk_valid && talk_ready) tq.push_back(talk_data);
    #DLY talk_ready = ~talk_ready;
  end
  ////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Data byte held until taken
  task automatic bus_put(input logic [7:0] b);
    bus_byte = b;
    bus_atn = 1'b0;
    bus_byte_valid = 1'b1;
    do @(posedge clk); while (bus_byte_ready !== 1'b1);
    #DLY bus_byte_valid = 1'b0;
    @(posedge clk);
    #DLY;
  endtask
  // Message byte, one cycle
  task automatic msg(input logic [7:0] c);
    bus_byte = c;
    bus_atn = 1'b1;
    bus_byte_valid = 1'b1;
    @(posedge clk);
    #DLY bus_byte_valid = 1'b0;
    bus_atn = 1'b0;
  endtask
  task automatic wait_chk(input logic [1:0] exp);
    repeat (6) @(posedge clk);
    #DLY chk({remote_ind, lockout_ind}, exp);
  endtask
  task automatic key(input logic exp);
    key_code = 8'h35;
    key_valid = 1'b1;
    @(posedge clk);
    #DLY key_valid = 1'b0;
    chk(panel_valid, exp);
    if (exp) chk(panel_code, 8'h35);
  endtask
  ////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    @(posedge clk);
    #DLY chk({remote_ind, lockout_ind, cmd_valid, txp, rx_overrun}, 5'b00010);
    $display("reset test done");
  endtask
  // Query over the bus with the receiver stalled until the buffer refuses
  task automatic t_bus();
    logic [7:0] s [6];
    logic [7:0] u;
    s = '{8'h2A, 8'h69, 8'h64, 8'h6E, 8'h3F, 8'h0D};
    cmd_ready = 1'b0;
    for (int k = 0; k < 3; k++) bus_put(s[k]);
    repeat (10) @(posedge clk);
    #DLY chk({bus_byte_ready, cmd_valid, txp}, 3'b010);
    cmd_ready = 1'b1;
    for (int k = 3; k < 6; k++) bus_put(s[k]);
    repeat (20) @(posedge clk);
    #DLY chk(cq.size(), 6);
    for (int k = 0; k < 6 && k < cq.size(); k++)
    begin
      u = (s[k] inside {[8'h61:8'h7A]}) ? s[k] - 8'h20 : s[k];
      chk(cq[k], {1'b1, 1'b1, k == 5, u});
    end
    for (int i = 0; i < 400 && tq.size() < 16; i++) @(posedge clk);
    #DLY chk(tq.size(), 16);
    for (int k = 0; k < 16 && k < tq.size(); k++) chk(tq[k], ID_T[8*(15-k) +: 8]);
    $display("bus test done");
  endtask
  task automatic t_states();
    key(1'b1);
    bus_listen = 1'b1;
    ren_pin = 1'b1;
    wait_chk(2'b10);
    key(1'b0);
    key_local_pin = 1'b1;
    wait_chk(2'b00);
    key_local_pin = 1'b0;
    ren_pin = 1'b0;
    wait_chk(2'b00);
    ren_pin = 1'b1;
    wait_chk(2'b10);
    msg(`RLC_MSG_GTL);
    wait_chk(2'b00);
    msg(`RLC_MSG_LLO);
    wait_chk(2'b01);
    ren_pin = 1'b0;
    wait_chk(2'b00);
    ren_pin = 1'b1;
    wait_chk(2'b10);
    msg(`RLC_MSG_LLO);
    wait_chk(2'b11);
    key_local_pin = 1'b1;
    wait_chk(2'b11);
    key_local_pin = 1'b0;
    msg(`RLC_MSG_GTL);
    wait_chk(2'b01);
    bus_listen = 1'b0;
    @(posedge clk);
    #DLY bus_listen = 1'b1;
    wait_chk(2'b11);
    ren_pin = 1'b0;
    wait_chk(2'b00);
    $display("state test done");
  endtask
  // Lower-case byte from the host over the serial line
  task automatic t_serial();
    cq.delete();
    serial_host_i.send(8'h71);
    for (int i = 0; i < 3000 && cq.size() == 0; i++) @(posedge clk);
    #DLY chk(cq.size(), 1);
    if (cq.size() > 0) chk(cq[0], {3'b000, 8'h51});
    $display("serial test done");
  endtask
  ////////////////////////////////////////////////////////////////////
  initial
  begin
    rst = 1'b1;
    ce = 1'b1;
    {ren_pin, bus_listen, bus_atn, bus_byte_valid, key_local_pin, key_valid} = '0;
    {bus_byte, key_code} = '0;
    cmd_ready = 1'b1;
    repeat (16) @(posedge clk);
    #DLY rst = 1'b0;
    t_reset();
    t_bus();
    t_states();
    t_serial();
    finish_test();
  end
  // Watchdog past XOFF, XON and one frame
  initial
  begin
    repeat (60000) @(posedge clk);
    error_cnt++;
    finish_test();
  end
endmodule
